/* File: rtl/bcs_sequencer.sv */
// How it works
// - Enable high closes switch, low opens it.
// - Enable toggle clears a latched fault, restarts.
// - One second cool-down before any restart.
// - Filtered primary overcurrent opens and latches.
// - Secondary overcurrent opens switch without filtering.
// - Current monitor off while ready is low.
// - Short and overtemperature detected without monitor.
// - Ready low when disabled or faulted.
// - Ready low during 10 ms start phase.
// - Ready released when start phase ends.
// - Channels sequence independently except shared faults.
// - Output still short after 300 us latches fault.
// - Overtemperature turns both channels off together.
`timescale 1ns/10ps
module bcs_sequencer #(
  parameter logic [19:0] START_TICKS = 20'(bcs_pkg::START_TICKS_DEF),
  parameter logic [19:0] COOL_TICKS = 20'(bcs_pkg::COOL_TICKS_DEF),
  parameter bit AUTO_RETRY = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic channel_one_enable,
  input wire logic channel_two_enable,
  input wire bcs_pkg::bcs_cmp_s channel_one_cmp,
  input wire bcs_pkg::bcs_cmp_s channel_two_cmp,
  input wire logic over_temp,
  input wire logic channel_one_ready_in,
  input wire logic channel_two_ready_in,
  output logic channel_one_ready_out,
  output logic channel_one_ready_oe_n,
  output logic channel_two_ready_out,
  output logic channel_two_ready_oe_n,
  output bcs_pkg::bcs_sw_s channel_one_sw,
  output bcs_pkg::bcs_sw_s channel_two_sw
);

  // The start timer must outlast the short-circuit window and the cool-down must not be zero.
  if (START_TICKS <= 20'(bcs_pkg::SC_TICKS) || COOL_TICKS == '0) begin : g_bad_param
    $error("Start ticks must exceed the short window and cool ticks must be nonzero.");
  end

  // Registered state and its next value.
  bcs_pkg::bcs_state_s s_reg;
  bcs_pkg::bcs_state_s s_next;
  // One-cycle time base strobe.
  logic tick;
  // Working copies of one channel inside the loop.
  bcs_pkg::bcs_chan_s c_v;
  bcs_pkg::bcs_chan_s n_v;
  // Enable level as seen by the sequencer this cycle.
  logic en_v;
  // Channel inputs gathered as vectors for the loop.
  logic [1:0] en_in;
  bcs_pkg::bcs_cmp_s [1:0] cmp_in;

  assign en_in = {channel_two_enable, channel_one_enable};
  assign cmp_in = {channel_two_cmp, channel_one_cmp};

  // Enters the latched fault state and arms the cool-down timer.
  function automatic bcs_pkg::bcs_chan_s enter_fault(input bcs_pkg::bcs_chan_s x,
                                                     input logic [19:0] cool);
    bcs_pkg::bcs_chan_s y;
    y = x;
    y.st = bcs_pkg::BCS_FAULT;
    y.cnt = cool;
    y.rearm = 1'b0;
    y.filt = '0;
    return y;
  endfunction : enter_fault

  // Next-state logic for the divider and both channels.
  always_comb begin
    s_next = s_reg;
    c_v = s_reg.ch[0];
    n_v = s_reg.ch[0];
    en_v = 1'b0;
    // The divider gives one tick per microsecond of time base.
    tick = (s_reg.div == bcs_pkg::TICK_CYC - 4'h1);
    s_next.div = tick ? 4'h0 : s_reg.div + 4'h1;
    // Each channel runs the same sequence on its own state.
    for (int i = 0; i < 2; i++) begin
      c_v = s_reg.ch[i];
      n_v = c_v;
      // Enable is resampled only on ticks, so brief glitches are missed.
      en_v = tick ? en_in[i] : c_v.en_smp;
      n_v.en_smp = en_v;
      case (c_v.st)
        bcs_pkg::BCS_OFF: begin
          // A high enable starts the current-limited phase.
          if (en_v) begin
            n_v.st = bcs_pkg::BCS_START;
            n_v.cnt = '0;
          end
        end
        bcs_pkg::BCS_START: begin
          if (!en_v) begin
            // Dropping enable abandons the start at once, with no fault kept.
            n_v.st = bcs_pkg::BCS_OFF;
          end else if (over_temp) begin
            // The temperature flag is shared, so both channels trip together.
            n_v = enter_fault(c_v, COOL_TICKS);
          end else if (tick && c_v.cnt == 20'(bcs_pkg::SC_TICKS - 1)
                       && cmp_in[i].out_short) begin
            // The output never charged within the window.
            n_v = enter_fault(c_v, COOL_TICKS);
          end else if (tick && c_v.cnt == START_TICKS - 20'h1) begin
            // The limited phase is over; ready and the monitor follow next edge.
            n_v.st = bcs_pkg::BCS_ON;
            n_v.filt = '0;
          end else if (tick) begin
            // Ready stays pulled low for as long as this timer runs.
            n_v.cnt = c_v.cnt + 20'h1;
          end
        end
        bcs_pkg::BCS_ON: begin
          if (!en_v) begin
            n_v.st = bcs_pkg::BCS_OFF;
          end else if (over_temp || cmp_in[i].out_short) begin
            // Both act even when a grounded monitor hides every overcurrent.
            n_v = enter_fault(c_v, COOL_TICKS);
          end else if (cmp_in[i].oc_secondary) begin
            // Severe overcurrent acts on the very next clock, not on a tick.
            n_v = enter_fault(c_v, COOL_TICKS);
          end else if (tick) begin
            // The primary result must hold for the whole filter span.
            if (!cmp_in[i].oc_primary) begin
              n_v.filt = '0;
            end else if (c_v.filt == 6'(bcs_pkg::PRI_FILT_TICKS - 1)) begin
              n_v = enter_fault(c_v, COOL_TICKS);
            end else begin
              n_v.filt = c_v.filt + 6'h01;
            end
          end
        end
        default: begin
          // Latched fault: the cool-down counter runs out before any restart.
          // A low enable seen while latched arms the restart.
          if (!en_v) begin
            n_v.rearm = 1'b1;
          end
          if (c_v.cnt != '0) begin
            if (tick) begin
              n_v.cnt = c_v.cnt - 20'h1;
            end
          end else if (en_v && (c_v.rearm || AUTO_RETRY)) begin
            // A rising edge during cool-down is kept and served here.
            n_v.st = bcs_pkg::BCS_START;
            n_v.cnt = '0;
            n_v.rearm = 1'b0;
          end else if (!en_v) begin
            // Cool-down is over and enable is low, so the channel rests off.
            n_v.st = bcs_pkg::BCS_OFF;
            n_v.rearm = 1'b0;
          end
        end
      endcase
      // Outputs follow the next state so they leave straight from flops.
      n_v.sw.breaker_switch = (n_v.st == bcs_pkg::BCS_START)
                              || (n_v.st == bcs_pkg::BCS_ON);
      n_v.sw.inrush_limit = (n_v.st == bcs_pkg::BCS_START);
      n_v.sw.monitor_enable = (n_v.st == bcs_pkg::BCS_ON);
      n_v.rdy_oe_n = (n_v.st == bcs_pkg::BCS_ON);
      s_next.ch[i] = n_v;
    end
  end

  // State register; reset leaves both channels off with ready pulled low.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // The ready pins only ever pull low; the enable alone sets the level.
  assign channel_one_ready_out = 1'b0;
  assign channel_two_ready_out = 1'b0;
  assign channel_one_ready_oe_n = s_reg.ch[0].rdy_oe_n;
  assign channel_two_ready_oe_n = s_reg.ch[1].rdy_oe_n;
  assign channel_one_sw = s_reg.ch[0].sw;
  assign channel_two_sw = s_reg.ch[1].sw;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Checks that apply to each channel alike.
  for (genvar g = 0; g < 2; g++) begin : g_chk
    property p_low_en_opens;
      !s_reg.ch[g].en_smp |-> !s_reg.ch[g].sw.breaker_switch && !s_reg.ch[g].rdy_oe_n;
    endproperty
    a_low_en_opens: assert property (p_low_en_opens)
      else $error("Switch closed or ready released with enable low.");

    property p_start_closes;
      ($rose(s_reg.ch[g].en_smp) && $past(s_reg.ch[g].st) == bcs_pkg::BCS_OFF)
        |-> s_reg.ch[g].sw.breaker_switch && s_reg.ch[g].sw.inrush_limit;
    endproperty
    a_start_closes: assert property (p_start_closes)
      else $error("Enable rise did not close the switch in current limit.");

    property p_ready_after_start;
      $rose(s_reg.ch[g].rdy_oe_n)
        |-> $past(s_reg.ch[g].st) == bcs_pkg::BCS_START
        && $past(s_reg.ch[g].cnt) == START_TICKS - 20'h1;
    endproperty
    a_ready_after_start: assert property (p_ready_after_start)
      else $error("Ready released before the full start phase.");

    property p_start_holds_ready;
      $rose(s_reg.ch[g].sw.breaker_switch) |-> !s_reg.ch[g].rdy_oe_n [*8];
    endproperty
    a_start_holds_ready: assert property (p_start_holds_ready)
      else $error("Ready released at start of inrush.");

    property p_monitor_gated;
      !s_reg.ch[g].rdy_oe_n |-> !s_reg.ch[g].sw.monitor_enable;
    endproperty
    a_monitor_gated: assert property (p_monitor_gated)
      else $error("Monitor enabled while ready is low.");

    property p_secondary_fast;
      (s_reg.ch[g].st == bcs_pkg::BCS_ON && s_reg.ch[g].en_smp && !tick
       && cmp_in[g].oc_secondary) |=> !s_reg.ch[g].sw.breaker_switch;
    endproperty
    a_secondary_fast: assert property (p_secondary_fast)
      else $error("Secondary overcurrent did not open the switch next cycle.");

    property p_primary_filtered;
      (s_reg.ch[g].st == bcs_pkg::BCS_ON && tick && cmp_in[g].oc_primary && en_in[g]
       && s_reg.ch[g].filt == 6'(bcs_pkg::PRI_FILT_TICKS - 1))
        |=> s_reg.ch[g].st == bcs_pkg::BCS_FAULT && !s_reg.ch[g].rdy_oe_n;
    endproperty
    a_primary_filtered: assert property (p_primary_filtered)
      else $error("Filtered primary overcurrent did not latch a fault.");

    property p_short_window;
      (s_reg.ch[g].st == bcs_pkg::BCS_START && tick && en_in[g] && cmp_in[g].out_short
       && s_reg.ch[g].cnt == 20'(bcs_pkg::SC_TICKS - 1))
        |=> s_reg.ch[g].st == bcs_pkg::BCS_FAULT;
    endproperty
    a_short_window: assert property (p_short_window)
      else $error("Short at window end did not latch a fault.");

    property p_cool_blocks;
      (s_reg.ch[g].st == bcs_pkg::BCS_FAULT && s_reg.ch[g].cnt != '0)
        |=> s_reg.ch[g].st == bcs_pkg::BCS_FAULT && !s_reg.ch[g].sw.breaker_switch;
    endproperty
    a_cool_blocks: assert property (p_cool_blocks)
      else $error("Channel left fault before cool-down ended.");

    property p_toggle_restarts;
      (s_reg.ch[g].st == bcs_pkg::BCS_FAULT && s_reg.ch[g].cnt == '0
       && s_reg.ch[g].rearm && !tick && s_reg.ch[g].en_smp)
        |=> s_reg.ch[g].st == bcs_pkg::BCS_START;
    endproperty
    a_toggle_restarts: assert property (p_toggle_restarts)
      else $error("Toggled enable did not restart after cool-down.");

    property p_overtemp_both;
      (over_temp && s_reg.ch[g].st == bcs_pkg::BCS_ON && en_in[g])
        |=> s_reg.ch[g].st == bcs_pkg::BCS_FAULT;
    endproperty
    a_overtemp_both: assert property (p_overtemp_both)
      else $error("Overtemperature did not latch the channel.");

    property p_fault_opens;
      $rose(s_reg.ch[g].st == bcs_pkg::BCS_FAULT)
        |-> !s_reg.ch[g].sw.breaker_switch && !s_reg.ch[g].sw.monitor_enable
        && !s_reg.ch[g].rdy_oe_n;
    endproperty
    a_fault_opens: assert property (p_fault_opens)
      else $error("Fault left the switch closed or ready released.");

    property p_cool_loaded;
      $rose(s_reg.ch[g].st == bcs_pkg::BCS_FAULT) |-> s_reg.ch[g].cnt == COOL_TICKS;
    endproperty
    a_cool_loaded: assert property (p_cool_loaded)
      else $error("Cool-down timer not loaded with its full length.");

    // Only the retry variant may leave a fault with no enable toggle.
    property p_retry_restarts;
      (AUTO_RETRY && s_reg.ch[g].st == bcs_pkg::BCS_FAULT && s_reg.ch[g].cnt == '0
       && !tick && s_reg.ch[g].en_smp)
        |=> s_reg.ch[g].st == bcs_pkg::BCS_START;
    endproperty
    a_retry_restarts: assert property (p_retry_restarts)
      else $error("Retry variant did not restart after cool-down.");

    // Covers show that each main path is reached at least once.
    c_reaches_on: cover property ($rose(s_reg.ch[g].rdy_oe_n));
    c_fault_latched: cover property ($rose(s_reg.ch[g].st == bcs_pkg::BCS_FAULT));
    c_restart: cover property (s_reg.ch[g].st == bcs_pkg::BCS_FAULT
                               ##1 s_reg.ch[g].st == bcs_pkg::BCS_START);
    c_fast_trip: cover property (s_reg.ch[g].st == bcs_pkg::BCS_ON && cmp_in[g].oc_secondary
                                 ##1 s_reg.ch[g].st == bcs_pkg::BCS_FAULT);
    c_short_trip: cover property (s_reg.ch[g].st == bcs_pkg::BCS_START && cmp_in[g].out_short
                                  ##1 s_reg.ch[g].st == bcs_pkg::BCS_FAULT);
  end

endmodule : bcs_sequencer

/* File: rtl/bcs_pkg.sv */
package bcs_pkg;

  // Clock period and the internal time base tick, both in nanoseconds.
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 1000;
  // Clock cycles per time base tick, the divider length.
  localparam logic [3:0] TICK_CYC = 4'(TICK_NS / CLK_NS);

  // Printed durations in their own units.
  localparam int START_MS = 10;
  localparam int SC_US = 300;
  localparam int COOL_S = 1;
  localparam int PRI_FILT_US = 50;

  // Durations as tick counts, derived from the time base.
  localparam int TICK_PER_US = 1000 / TICK_NS > 0 ? 1000 / TICK_NS : 1;
  localparam int START_TICKS_DEF = START_MS * 1000 * 1000 / TICK_NS;
  localparam int SC_TICKS = SC_US * 1000 / TICK_NS;
  localparam int COOL_TICKS_DEF = COOL_S * 1000 * 1000 * 1000 / TICK_NS;
  localparam int PRI_FILT_TICKS = PRI_FILT_US * 1000 / TICK_NS;

  // Counter widths for phase timers and the primary glitch filter.
  localparam int CNT_W = 20;
  localparam int FLT_W = 6;

  // Channel sequencer states.
  typedef enum logic [1:0] {
    BCS_OFF,
    BCS_START,
    BCS_ON,
    BCS_FAULT
  } bcs_state_e;

  // Comparator results for one channel, all active high.
  typedef struct packed {
    logic oc_primary;
    logic oc_secondary;
    logic out_short;
  } bcs_cmp_s;

  // Switch controls for one channel, all active high.
  typedef struct packed {
    logic breaker_switch;
    logic inrush_limit;
    logic monitor_enable;
  } bcs_sw_s;

  // Per-channel state.
  typedef struct packed {
    bcs_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [FLT_W-1:0] filt;
    logic en_smp;
    logic rearm;
    bcs_sw_s sw;
    logic rdy_oe_n;
  } bcs_chan_s;

  // Whole block state.
  typedef struct packed {
    logic [3:0] div;
    bcs_chan_s [1:0] ch;
  } bcs_state_s;

endpackage : bcs_pkg

/* File: dv/bcs_host.sv */
`timescale 1ns/10ps
// Controller model: drives both enables and reads the open-drain ready lines.
module bcs_host #(
  parameter int HOLD_CYC = 100
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] en_req,
  input wire logic [1:0] rdy_oe_n,
  input wire logic [1:0] rdy_out,
  output logic [1:0] en,
  output logic [1:0] rdy_pin
);
  logic [7:0] hold_reg [2]; // Cycles each enable level has been held.

  // Ready lines carry a pull-up, so a released line reads high.
  assign rdy_pin[0] = rdy_oe_n[0] ? 1'b1 : rdy_out[0];
  assign rdy_pin[1] = rdy_oe_n[1] ? 1'b1 : rdy_out[1];

  // A new enable level waits until the old one has stood long enough to be seen.
  always_ff @(posedge core_clk or posedge rst) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        en[i] <= 1'b0;
        hold_reg[i] <= 8'h00;
      end else if (en_req[i] != en[i] && hold_reg[i] >= 8'(HOLD_CYC - 1)) begin
        en[i] <= en_req[i];
        hold_reg[i] <= 8'h00;
      end else if (hold_reg[i] != 8'hFF) begin
        hold_reg[i] <= hold_reg[i] + 8'h01;
      end
    end
  end
endmodule : bcs_host

/* File: dv/tb_breaker_channel_sequencer.sv */
`timescale 1ns/10ps
module tb_breaker_channel_sequencer;
  localparam int ST = 400; // Start phase in ticks, shortened to keep the run brief.
  localparam int CT = 20; // Cool-down in ticks, shortened likewise.
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic over_temp = 1'b0;
  logic [1:0] en_req = 2'b00;
  logic [1:0] en;
  logic [1:0] rdy_pin;
  logic [1:0] rdy_oe_n;
  logic [1:0] rdy_o;
  bcs_pkg::bcs_cmp_s cmp [2] = '{default: '0};
  bcs_pkg::bcs_sw_s sw [2];
  logic [1:0] rdy_oe_n_r; // Ready enables of the retry variant.
  bcs_pkg::bcs_sw_s sw_r [2]; // Switch controls of the retry variant.
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;

  always #50 core_clk = ~core_clk;

  bcs_sequencer #(.START_TICKS(20'(ST)), .COOL_TICKS(20'(CT)), .AUTO_RETRY(1'b0)) u_dut (
    .core_clk(core_clk), .rst(rst), .channel_one_enable(en[0]), .channel_two_enable(en[1]),
    .channel_one_cmp(cmp[0]), .channel_two_cmp(cmp[1]), .over_temp(over_temp),
    .channel_one_ready_in(rdy_pin[0]), .channel_two_ready_in(rdy_pin[1]),
    .channel_one_ready_out(rdy_o[0]), .channel_one_ready_oe_n(rdy_oe_n[0]),
    .channel_two_ready_out(rdy_o[1]), .channel_two_ready_oe_n(rdy_oe_n[1]),
    .channel_one_sw(sw[0]), .channel_two_sw(sw[1]));

  bcs_host u_host (.core_clk(core_clk), .rst(rst), .en_req(en_req), .rdy_oe_n(rdy_oe_n),
    .rdy_out(rdy_o), .en(en), .rdy_pin(rdy_pin));

  // Retry variant on the same inputs, so only its fault recovery differs.
  bcs_sequencer #(.START_TICKS(20'(ST)), .COOL_TICKS(20'(CT)), .AUTO_RETRY(1'b1))
    u_dut_retry (
    .core_clk(core_clk), .rst(rst), .channel_one_enable(en[0]), .channel_two_enable(en[1]),
    .channel_one_cmp(cmp[0]), .channel_two_cmp(cmp[1]), .over_temp(over_temp),
    .channel_one_ready_in(rdy_oe_n_r[0]), .channel_two_ready_in(rdy_oe_n_r[1]),
    .channel_one_ready_out(), .channel_one_ready_oe_n(rdy_oe_n_r[0]),
    .channel_two_ready_out(), .channel_two_ready_oe_n(rdy_oe_n_r[1]),
    .channel_one_sw(sw_r[0]), .channel_two_sw(sw_r[1]));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Waits, with a bound, for the switch or the ready pin of a channel to reach a level.
  task wait_on(input int c, input bit pin, input logic v, input int lim);
    n = 0;
    while ((pin ? rdy_pin[c] : sw[c].breaker_switch) !== v && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask : wait_on

  // Enables a channel and follows it through the limited start phase.
  task run_start(input int c);
    @(posedge core_clk);
    en_req[c] <= 1'b1;
    wait_on(c, 0, 1'b1, 300);
    chk(sw[c].breaker_switch, 1'b1);
    chk({sw[c].inrush_limit, sw[c].monitor_enable, rdy_pin[c]}, 3'b100);
    wait_on(c, 1, 1'b1, ST * 10 + 100);
    chk(n >= ST * 10 - 150 && n < ST * 10 + 100, 1'b1);
    chk({sw[c].breaker_switch, sw[c].inrush_limit, sw[c].monitor_enable}, 3'b101);
  endtask : run_start

  // Drops enable long enough to clear a latched fault, then starts again.
  task restart(input int c);
    @(posedge core_clk);
    en_req[c] <= 1'b0;
    repeat (300) @(posedge core_clk);
    run_start(c);
  endtask : restart

  // A short burst must be filtered out; a sustained one must trip.
  task t_primary;
    @(posedge core_clk);
    cmp[0].oc_primary <= 1'b1;
    repeat (400) @(posedge core_clk);
    cmp[0].oc_primary <= 1'b0;
    #1;
    chk(sw[0].breaker_switch, 1'b1);
    repeat (30) @(posedge core_clk);
    cmp[0].oc_primary <= 1'b1;
    wait_on(0, 0, 1'b0, 700);
    chk(n >= 460 && n < 700, 1'b1);
    chk({sw[0].monitor_enable, rdy_pin[0]}, 2'b00);
    @(posedge core_clk);
    cmp[0].oc_primary <= 1'b0;
    restart(0);
  endtask : t_primary

  // A fast trip, then a toggle inside the cool-down that must be held off.
  task t_secondary;
    @(posedge core_clk);
    cmp[0].oc_secondary <= 1'b1;
    wait_on(0, 0, 1'b0, 4);
    chk({n < 4, sw[0], rdy_pin[0]}, 5'h10);
    @(posedge core_clk);
    cmp[0].oc_secondary <= 1'b0;
    en_req[0] <= 1'b0;
    repeat (110) @(posedge core_clk);
    en_req[0] <= 1'b1;
    repeat (40) @(posedge core_clk);
    #1;
    chk(sw[0].breaker_switch, 1'b0);
    wait_on(0, 0, 1'b1, 300);
    chk(n + 150 >= CT * 10 - 20 && n < 300, 1'b1);
    run_start(0);
  endtask : t_secondary

  // Output held low through the evaluation window on channel two only.
  task t_short;
    @(posedge core_clk);
    cmp[1].out_short <= 1'b1;
    en_req[1] <= 1'b1;
    wait_on(1, 0, 1'b1, 300);
    repeat (2850) @(posedge core_clk);
    #1;
    chk(sw[1].breaker_switch, 1'b1);
    wait_on(1, 0, 1'b0, 300);
    chk(n < 300, 1'b1);
    chk({rdy_pin[1], sw[0].breaker_switch, rdy_pin[0]}, 3'b011);
    @(posedge core_clk);
    cmp[1].out_short <= 1'b0;
    restart(1);
  endtask : t_short

  // Shared overtemperature drops both channels; enables must be toggled.
  task t_overtemp;
    @(posedge core_clk);
    over_temp <= 1'b1;
    @(posedge core_clk);
    over_temp <= 1'b0;
    wait_on(0, 0, 1'b0, 3);
    chk({sw[0], sw[1], rdy_pin}, 8'h00);
    chk({sw_r[0], sw_r[1], rdy_oe_n_r}, 8'h00);
    repeat (400) @(posedge core_clk);
    #1;
    chk(sw[0].breaker_switch | sw[1].breaker_switch, 1'b0);
    chk({sw_r[0], sw_r[1], rdy_oe_n_r}, 8'hD8);
    @(posedge core_clk);
    en_req[1] <= 1'b0;
    restart(0);
    @(posedge core_clk);
    en_req[0] <= 1'b0;
    wait_on(0, 0, 1'b0, 150);
    chk({sw[0], rdy_pin[0]}, 4'h0);
  endtask : t_overtemp

  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Cuts a hang short well above the expected run length.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 50000) begin
      n_fail++;
      wrap_up;
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    run_start(0);
    t_primary;
    t_secondary;
    t_short;
    t_overtemp;
    wrap_up;
  end
endmodule : tb_breaker_channel_sequencer
